// *** hdl/gme_regs.sv ***
// What this block does
// [R01] A pin is a high-impedance input unless its direction bit is set.
// [R02] An output pin is driven high while its output-level bit is set.
// [R03] Input-state field returns each pin's buffered level; writes to it do nothing.
// [R04] Pin input states are captured at the address parity end of a read.
// [R05] Timer mode overrides pin 3: high while counting, low once expired.
// [R06] Emergency discharge mode forces pin-3 timer mode regardless of its bit.
// [R07] Bits between timer-mode bit and output-level field always read zero.
// [R08] Divider connect bit attaches stack divider; software sets it before measuring.
// [R09] Stack input converted only when its enable bit is set.
// [R10] Auxiliary input 2 converted only when its enable bit is set.
// [R11] Auxiliary input 1 converted only when its enable bit is set.
// [R12] Cell enable bit n controls conversion of cell n+1.
// [R13] Result of a disabled channel is stored as zero.
// [R14] Output pin with level bit clear and no timer control drives zero.
module gme_regs
    import gme_pkg::*;
#(
    parameter int NPINS  = 4,
    parameter int NCELLS = 12,
    parameter int RES_W  = 16
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hce,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic [31:0]            hrdata,
    output logic                   hresp,
    input  wire logic [NPINS-1:0]  pin_in,
    output logic [NPINS-1:0]       pin_out,
    output logic [NPINS-1:0]       pin_oe_n,
    input  wire logic              timer_counting,
    input  wire logic              emergency_discharge_mode,
    input  wire logic              link_rd_parity_end,
    output logic                   stack_divider_connect,
    output logic                   stack_input_enable,
    output logic                   aux2_measure_enable,
    output logic                   aux1_measure_enable,
    output logic [NCELLS-1:0]      cell_channel_enables,
    input  wire logic              adc_valid,
    input  wire logic [3:0]        adc_chan,
    input  wire logic [RES_W-1:0]  adc_data,
    output logic                   result_valid,
    output logic [3:0]             result_chan,
    output logic [RES_W-1:0]       result_data
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic chan_enabled(input logic [15:0] en, input logic [3:0] ch);
        logic r;
        r = 1'b0;
        if (ch == GME_CH_STACK) begin
            r = en[GME_STACK_BIT];
        end else if (ch == GME_CH_AUX2) begin
            r = en[GME_AUX2_BIT];
        end else if (ch == GME_CH_AUX1) begin
            r = en[GME_AUX1_BIT];
        end else if (ch < 4'(NCELLS)) begin
            r = en[GME_CELL_LSB + 32'(ch)];
        end
        return r;
    endfunction

    function automatic gme_sel_t decode(input logic [31:0] a);
        gme_sel_t s;
        s = GME_CMP_IDLE;
        if (a[9:0] == GME_PIN_CTRL_ADDR) begin
            s = GME_CMP_GPIO;
        end else if (a[9:0] == GME_MEAS_EN_ADDR) begin
            s = GME_CMP_MEAS;
        end
        return s;
    endfunction

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [NPINS-1:0]  dir_reg;
    logic [NPINS-1:0]  lvl_reg;
    logic              tmr_reg;
    logic [15:0]       meas_reg;
    logic [NPINS-1:0]  rd_state_reg;
    logic [NPINS-1:0]  sync1_reg;
    logic [NPINS-1:0]  sync2_reg;
    logic [NPINS-1:0]  sync3_reg;
    logic [NPINS-1:0]  pin_state_reg;
    gme_sel_t          dsel_reg;
    logic              dwrite_reg;

    logic              addr_ok;
    gme_sel_t          asel;
    logic              tmr_active;
    logic [NPINS-1:0]  pin_out_next;
    logic [NPINS-1:0]  pin_oe_n_next;
    logic [31:0]       rdata_next;
    logic              capture;

    assign addr_ok    = hsel && hready && (htrans == GME_HTRANS_NONSEQ);
    assign asel       = decode(haddr);
    assign tmr_active = tmr_reg || emergency_discharge_mode;       // [R06]
    // AHB read of the pin register takes the same sample point as the link
    assign capture    = link_rd_parity_end ||
                        (addr_ok && !hwrite && asel == GME_CMP_GPIO);

    // ------------------------------------------------------------------
    // AHB slave
    // ------------------------------------------------------------------
    // Zero wait states; the bus must stay idle while hce is low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= GME_HRESP_OKAY;
            dsel_reg  <= GME_CMP_IDLE;
            dwrite_reg <= 1'b0;
        end else if (hce) begin
            hreadyout <= 1'b1;
            hresp     <= GME_HRESP_OKAY;
            dsel_reg  <= addr_ok ? asel : GME_CMP_IDLE;
            dwrite_reg <= addr_ok && hwrite;
        end
    end

    always_comb begin
        rdata_next = GME_ZERO_WORD;
        unique case (asel)
            GME_CMP_GPIO: begin
                rdata_next[GME_DIR_LSB +: NPINS] = dir_reg;
                rdata_next[GME_RD_LSB  +: NPINS] = pin_state_reg;      // [R03]
                rdata_next[GME_TMR_BIT]          = tmr_reg;
                rdata_next[GME_LVL_LSB +: NPINS] = lvl_reg;            // [R07]
            end
            GME_CMP_MEAS: begin
                rdata_next[15:0] = meas_reg;
            end
            GME_CMP_IDLE: begin
                rdata_next = GME_ZERO_WORD;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= GME_ZERO_WORD;
        end else if (hce && addr_ok && !hwrite) begin
            hrdata <= rdata_next;
        end
    end

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dir_reg <= GME_PIN_CTRL_RST[GME_DIR_LSB +: NPINS];
            lvl_reg <= GME_PIN_CTRL_RST[GME_LVL_LSB +: NPINS];
            tmr_reg <= GME_PIN_CTRL_RST[GME_TMR_BIT];
        end else if (hce && dwrite_reg && dsel_reg == GME_CMP_GPIO) begin
            // Input-state and reserved bits are not stored
            dir_reg <= hwdata[GME_DIR_LSB +: NPINS];                   // [R01] [R03]
            lvl_reg <= hwdata[GME_LVL_LSB +: NPINS];                   // [R02]
            tmr_reg <= hwdata[GME_TMR_BIT];                            // [R05]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meas_reg <= GME_MEAS_EN_RST;
        end else if (hce && dwrite_reg && dsel_reg == GME_CMP_MEAS) begin
            meas_reg <= hwdata[15:0];
        end
    end

    // ------------------------------------------------------------------
    // Pin input path
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
        end else if (hce) begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // A level counts only once two stages agree, filtering metastable settles
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_state_reg <= '0;
        end else if (hce) begin
            for (int n = 0; n < NPINS; n++) begin
                if (sync2_reg[n] == sync3_reg[n]) begin
                    pin_state_reg[n] <= sync3_reg[n];
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_state_reg <= '0;
        end else if (hce && capture) begin
            rd_state_reg <= pin_state_reg;                             // [R04]
        end
    end

    // ------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------
    always_comb begin
        for (int n = 0; n < NPINS; n++) begin
            pin_oe_n_next[n] = !dir_reg[n];                            // [R01]
            pin_out_next[n]  = dir_reg[n] && lvl_reg[n];               // [R02] [R14]
        end
        if (tmr_active) begin
            pin_oe_n_next[GME_TMR_PIN] = 1'b0;                         // [R05]
            pin_out_next[GME_TMR_PIN]  = timer_counting;               // [R05]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_out  <= '0;
            pin_oe_n <= '1;
        end else if (hce) begin
            pin_out  <= pin_out_next;
            pin_oe_n <= pin_oe_n_next;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer enables and result masking
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stack_divider_connect <= 1'b0;
            stack_input_enable    <= 1'b0;
            aux2_measure_enable   <= 1'b0;
            aux1_measure_enable   <= 1'b0;
            cell_channel_enables  <= '0;
        end else if (hce) begin
            stack_divider_connect <= meas_reg[GME_CONNECT_BIT];                  // [R08]
            stack_input_enable    <= meas_reg[GME_STACK_BIT];                    // [R09]
            aux2_measure_enable   <= meas_reg[GME_AUX2_BIT];                     // [R10]
            aux1_measure_enable   <= meas_reg[GME_AUX1_BIT];                     // [R11]
            cell_channel_enables  <= meas_reg[GME_CELL_LSB +: NCELLS];           // [R12]
        end
    end

    // Disabled channels land as zero so stale data never looks valid
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_valid <= 1'b0;
            result_chan  <= '0;
            result_data  <= '0;
        end else if (hce) begin
            result_valid <= adc_valid;
            result_chan  <= adc_chan;
            result_data  <= chan_enabled(meas_reg, adc_chan) ? adc_data : '0;    // [R13]
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Write checks look two edges back, at the hwdata of the data phase
    sequence s_gpio_wr;
        hce && addr_ok && hwrite && asel == GME_CMP_GPIO ##1 hce;
    endsequence

    sequence s_meas_wr;
        hce && addr_ok && hwrite && asel == GME_CMP_MEAS ##1 hce;
    endsequence

    AST_DIR_INPUT: assert property (@(posedge hclk) disable iff (!hresetn) // [R01]
        hce && !dir_reg[0] |=> pin_oe_n[0])
        else $error("pin 0 driven with direction clear");

    AST_DRV_HIGH: assert property (@(posedge hclk) disable iff (!hresetn) // [R02]
        hce && dir_reg[1] && lvl_reg[1] |=> !pin_oe_n[1] && pin_out[1])
        else $error("pin 1 not driven high");

    AST_DRV_LOW: assert property (@(posedge hclk) disable iff (!hresetn) // [R14]
        hce && dir_reg[1] && !lvl_reg[1] |=> !pin_oe_n[1] && !pin_out[1])
        else $error("pin 1 not driven low");

    AST_RD_ONLY: assert property (@(posedge hclk) disable iff (!hresetn) // [R03]
        s_gpio_wr |=> pin_state_reg == $past(sync3_reg) ||
                      pin_state_reg == $past(pin_state_reg))
        else $error("input state changed by a write");

    AST_CAPTURE: assert property (@(posedge hclk) disable iff (!hresetn) // [R04]
        hce && link_rd_parity_end |=> rd_state_reg == $past(pin_state_reg))
        else $error("input state not captured at parity end");

    AST_TIMER: assert property (@(posedge hclk) disable iff (!hresetn) // [R05]
        hce && tmr_reg |=> !pin_oe_n[3] && pin_out[3] == $past(timer_counting))
        else $error("pin 3 not following timer");

    AST_EMERGENCY: assert property (@(posedge hclk) disable iff (!hresetn) // [R06]
        hce && emergency_discharge_mode && !tmr_reg |=> !pin_oe_n[3] &&
                                                        pin_out[3] == $past(timer_counting))
        else $error("emergency discharge did not take pin 3");

    AST_RESERVED: assert property (@(posedge hclk) disable iff (!hresetn) // [R07]
        hce && addr_ok && !hwrite && asel == GME_CMP_GPIO |=> hrdata[6:4] == 3'h0)
        else $error("reserved bits read non-zero");

    AST_CONNECT: assert property (@(posedge hclk) disable iff (!hresetn) // [R08]
        s_meas_wr ##1 hce |=> stack_divider_connect == $past(hwdata[GME_CONNECT_BIT], 2))
        else $error("divider connect not applied");

    AST_STACK_EN: assert property (@(posedge hclk) disable iff (!hresetn) // [R09]
        s_meas_wr ##1 hce |=> stack_input_enable == $past(hwdata[GME_STACK_BIT], 2))
        else $error("stack enable mismatch");

    AST_AUX_EN: assert property (@(posedge hclk) disable iff (!hresetn) // [R10] [R11]
        s_meas_wr ##1 hce |=> aux2_measure_enable == $past(hwdata[GME_AUX2_BIT], 2) &&
                              aux1_measure_enable == $past(hwdata[GME_AUX1_BIT], 2))
        else $error("aux enables mismatch");

    AST_CELL_EN: assert property (@(posedge hclk) disable iff (!hresetn) // [R12]
        s_meas_wr ##1 hce |=> cell_channel_enables == $past(hwdata[NCELLS-1:0], 2))
        else $error("cell enables mismatch");

    AST_ZERO_RESULT: assert property (@(posedge hclk) disable iff (!hresetn) // [R13]
        hce && adc_valid && !chan_enabled(meas_reg, adc_chan) |=> result_valid && result_data == '0)
        else $error("disabled channel result not zero");

    AST_PASS_RESULT: assert property (@(posedge hclk) disable iff (!hresetn) // [R12]
        hce && adc_valid && chan_enabled(meas_reg, adc_chan) |=>
            result_valid && result_data == $past(adc_data))
        else $error("enabled channel result altered");

endmodule

// *** shared/gme_pkg.sv ***
package gme_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0]  GME_PIN_CTRL_IDX   = 8'h11;
    localparam logic [7:0]  GME_MEAS_EN_IDX    = 8'h12;
    localparam logic [9:0]  GME_PIN_CTRL_ADDR  = {GME_PIN_CTRL_IDX, 2'b00};
    localparam logic [9:0]  GME_MEAS_EN_ADDR   = {GME_MEAS_EN_IDX, 2'b00};
    localparam logic [15:0] GME_PIN_CTRL_RST   = 16'h0000;
    localparam logic [15:0] GME_MEAS_EN_RST    = 16'h0000;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int GME_DIR_LSB      = 12;
    localparam int GME_RD_LSB       = 8;
    localparam int GME_TMR_BIT      = 7;
    localparam int GME_LVL_LSB      = 0;
    localparam int GME_CONNECT_BIT  = 15;
    localparam int GME_STACK_BIT    = 14;
    localparam int GME_AUX2_BIT     = 13;
    localparam int GME_AUX1_BIT     = 12;
    localparam int GME_CELL_LSB     = 0;
    localparam int GME_TMR_PIN      = 3;

    // ------------------------------------------------------------------
    // Channel codes on the result path
    // ------------------------------------------------------------------
    localparam logic [3:0]  GME_CH_AUX1        = 4'hc;
    localparam logic [3:0]  GME_CH_AUX2        = 4'hd;
    localparam logic [3:0]  GME_CH_STACK       = 4'he;

    // ------------------------------------------------------------------
    // AHB codes
    // ------------------------------------------------------------------
    localparam logic [1:0]  GME_HTRANS_NONSEQ  = 2'h2;
    localparam logic        GME_HRESP_OKAY     = 1'b0;
    localparam logic [31:0] GME_ZERO_WORD      = 32'h0000_0000;

    typedef enum logic [1:0] {
        GME_CMP_IDLE  = 2'b00,
        GME_CMP_GPIO  = 2'b01,
        GME_CMP_MEAS  = 2'b11
    } gme_sel_t;

endpackage

// *** verif/gme_far_model.sv ***
module gme_far_model (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic [3:0]  pin_out,
    input  wire logic [3:0]  pin_oe_n,
    input  wire logic [3:0]  ext_level,
    input  wire logic        acq_start,
    output logic [3:0]       pin_in,
    output logic             adc_valid,
    output logic [3:0]       adc_chan,
    output logic [15:0]      adc_data
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [3:0] chan_reg;

    // ------------------------------------------------------------------
    // Pin wires
    // ------------------------------------------------------------------
    // Driven pins win; released pins follow the outside source
    always_comb pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);

    // ------------------------------------------------------------------
    // Converter: channels 0..14 back to back, 15 is idle
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chan_reg <= 4'hf;
        end else if (acq_start) begin
            chan_reg <= 4'h0;
        end else if (chan_reg != 4'hf) begin
            chan_reg <= chan_reg + 4'h1;
        end
    end

    always_comb begin
        adc_valid = (chan_reg != 4'hf);
        adc_chan  = chan_reg;
        // Idle data is inverted so a stale sample never looks valid
        adc_data  = {12'h3c5, chan_reg} ^ {16{~adc_valid}};
    end
endmodule

// *** verif/tb.sv ***
module tb
    import gme_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        hclk, hresetn, hce, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, d;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  pin_in, pin_out, pin_oe_n, ext_level, adc_chan, result_chan;
    logic        timer_counting, emergency_discharge_mode, link_rd_parity_end;
    logic        acq_start, adc_valid, result_valid;
    logic        stack_divider_connect, stack_input_enable;
    logic        aux2_measure_enable, aux1_measure_enable;
    logic [11:0] cell_channel_enables;
    logic [15:0] adc_data, result_data, exp_mask;
    int          bad_count, cmp_count, res_n;

    gme_regs dut (
        .hclk(hclk), .hresetn(hresetn), .hce(hce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .timer_counting(timer_counting),
        .emergency_discharge_mode(emergency_discharge_mode),
        .link_rd_parity_end(link_rd_parity_end),
        .stack_divider_connect(stack_divider_connect),
        .stack_input_enable(stack_input_enable),
        .aux2_measure_enable(aux2_measure_enable),
        .aux1_measure_enable(aux1_measure_enable),
        .cell_channel_enables(cell_channel_enables),
        .adc_valid(adc_valid), .adc_chan(adc_chan), .adc_data(adc_data),
        .result_valid(result_valid), .result_chan(result_chan),
        .result_data(result_data)
    );

    gme_far_model far (
        .hclk(hclk), .hresetn(hresetn), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .ext_level(ext_level), .acq_start(acq_start), .pin_in(pin_in),
        .adc_valid(adc_valid), .adc_chan(adc_chan), .adc_data(adc_data)
    );

    always #50 hclk = ~hclk;

    // ------------------------------------------------------------------
    // Common tasks
    // ------------------------------------------------------------------
    task automatic final_report;
        if (bad_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input bit ok, input string msg);
        cmp_count++;
        if (!ok) begin
            bad_count++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            check(1'b0, "bus hang");
            final_report;
        end
    endtask

    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        htrans <= GME_HTRANS_NONSEQ;
        haddr  <= a;
        hwrite <= wr;
        wait_ready;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready;
        d = hrdata;
        check(hresp === GME_HRESP_OKAY, "response");
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // Result stream: disabled channels must come back as zero
    always @(posedge hclk) begin
        if (result_valid === 1'b1) begin
            check(result_chan === res_n[3:0], "result channel");
            check(result_data === (exp_mask[result_chan] ? {12'h3c5, result_chan}
                                                         : 16'h0000), "result");
            res_n++;
        end
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        check(pin_oe_n === 4'hf, "pins not released");
        xfer(1'b0, {22'h0, GME_PIN_CTRL_ADDR}, 32'h0);
        check(d === {16'h0, GME_PIN_CTRL_RST}, "pin reg reset");
        xfer(1'b0, {22'h0, GME_MEAS_EN_ADDR}, 32'h0);
        check(d === {16'h0, GME_MEAS_EN_RST}, "meas reg reset");
    endtask

    task automatic t_pins;
        xfer(1'b1, {22'h0, GME_PIN_CTRL_ADDR}, 32'h0000_ff75);
        settle(3);
        check(pin_oe_n === 4'h0, "all pins drive");
        check(pin_out === 4'h5, "drive levels");
        settle(8);
        xfer(1'b0, {22'h0, GME_PIN_CTRL_ADDR}, 32'h0);
        check(d === 32'h0000_f505, "pin readback");
        xfer(1'b1, {22'h0, GME_PIN_CTRL_ADDR}, 32'h0000_a00f);
        settle(3);
        check(pin_oe_n === 4'h5, "mixed direction");
        check((pin_out & 4'ha) === 4'ha, "driven highs");
    endtask

    task automatic t_instate;
        xfer(1'b1, {22'h0, GME_PIN_CTRL_ADDR}, 32'h0);
        ext_level <= 4'h9;
        settle(8);
        xfer(1'b0, {22'h0, GME_PIN_CTRL_ADDR}, 32'h0);
        check(d === 32'h0000_0900, "input state");
        ext_level <= 4'h6;
        settle(8);
        link_rd_parity_end <= 1'b1;
        @(posedge hclk);
        link_rd_parity_end <= 1'b0;
        xfer(1'b0, {22'h0, GME_PIN_CTRL_ADDR}, 32'h0);
        check(d[11:8] === 4'h6, "input state after link");
    endtask

    task automatic t_timer;
        xfer(1'b1, {22'h0, GME_PIN_CTRL_ADDR}, 32'h0000_0080);
        timer_counting <= 1'b1;
        settle(3);
        check({pin_oe_n, pin_out[3]} === 5'b0111_1, "timer counting");
        timer_counting <= 1'b0;
        settle(3);
        check({pin_oe_n[3], pin_out[3]} === 2'b00, "timer expired");
        xfer(1'b1, {22'h0, GME_PIN_CTRL_ADDR}, 32'h0000_8008);
        emergency_discharge_mode <= 1'b1;
        settle(3);
        check({pin_oe_n[3], pin_out[3]} === 2'b00, "emergency low");
        timer_counting <= 1'b1;
        settle(3);
        check(pin_out[3] === 1'b1, "emergency high");
        emergency_discharge_mode <= 1'b0;
        timer_counting <= 1'b0;
        settle(3);
        check(pin_out[3] === 1'b1, "level again");
    endtask

    task automatic t_meas;
        // Stack enable only with the divider connected
        logic [15:0] masks [4] = '{16'h0000, 16'hffff, 16'h8a53, 16'hcac5};
        foreach (masks[i]) begin
            xfer(1'b1, {22'h0, GME_MEAS_EN_ADDR}, {16'h0, masks[i]});
            xfer(1'b1, 32'h0000_004c, 32'hffff_ffff);
            xfer(1'b0, {22'h0, GME_MEAS_EN_ADDR}, 32'h0);
            check(d === {16'h0, masks[i]}, "meas readback");
            xfer(1'b0, 32'h0000_004c, 32'h0);
            check(d === 32'h0, "unmapped read");
            settle(3);
            check({stack_divider_connect, stack_input_enable, aux2_measure_enable,
                   aux1_measure_enable, cell_channel_enables} === masks[i],
                  "enables");
            exp_mask = masks[i];
            res_n = 0;
            acq_start <= 1'b1;
            @(posedge hclk);
            acq_start <= 1'b0;
            settle(20);
            check(res_n == 15, "result count");
        end
    endtask

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hce = 1'b1;
        hsel = 1'b1;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        ext_level = 4'h0;
        timer_counting = 1'b0;
        emergency_discharge_mode = 1'b0;
        link_rd_parity_end = 1'b0;
        acq_start = 1'b0;
        exp_mask = 16'h0;
        bad_count = 0;
        cmp_count = 0;
        res_n = 0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset;
        t_pins;
        t_instate;
        t_timer;
        t_meas;
        final_report;
    end
endmodule
